// ===== hdl/agc_core.sv
// Address generation, mode select, return stack and operand decode.
//
// Functional notes
// RULE1: Mode pin level at reset picks mode.
// RULE2: Microcomputer mode fetches from on-chip memory.
// RULE3: Microprocessor mode fetches all 4K externally.
// RULE4: Calls and interrupts push PC, four deep.
// RULE5: Fifteen maskable interrupts plus one nonmaskable.
// RULE6: I/O drives three address lines, nine high.
// RULE7: I/O port number is three-bit field.
// RULE8: External-flag branch is a two-cycle nop.
// RULE9: Direct address is page bit plus seven.
// RULE10: Indirect address is selected aux low byte.
// RULE11: Indirect ops modify aux and pointer together.
// RULE12: Indirect mode only for data-operand instructions.
// RULE13: Immediate ops take operand from instruction.
// RULE14: One bit selects which aux register.
// RULE15: Four-bit shift code, three-bit store shift.
// RULE16: Single cycle except branch and I/O.
// RULE17: Input shifter: 0..16 left, sign extend.
// RULE18: Output shifter: accumulator left 0, 1, 4.
// RULE19: Mode bit 0 direct, 1 indirect.
// RULE20: Fifth push overwrites the deepest entry.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module agc_core (
	input wire logic sys_clk, // 10 MHz core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic modeSelectNonmaskPin, // Mode strap in reset, nonmaskable request after.
	input wire logic instrValid, // Instruction word present this cycle.
	input wire logic [15:0] instrWord, // Instruction or second branch word.
	input wire logic branchCond, // Condition result for conditional branches.
	input wire logic [14:0] irqReq, // Maskable interrupt request levels.
	input wire logic [15:0] loadData, // Data word for the input shifter.
	input wire logic shiftSixteen, // Shift by sixteen instead of the code.
	input wire logic [31:0] accIn, // Accumulator for the output shifter.
	input wire logic [1:0] regAddr, // Register index.
	input wire logic [15:0] regWrData, // Register write data.
	input wire logic regWr, // Register write strobe.
	input wire logic regRd, // Register read strobe.
	output logic [15:0] regRdData, // Read data, cycle after the strobe.
	output logic busy, // Second cycle of a two cycle operation.
	output logic [11:0] progAddr, // Program counter.
	output logic progExternal, // Fetch goes to the external bus.
	output logic progOnChip, // Fetch goes to on-chip memory.
	output logic [7:0] dataAddr, // Data memory address.
	output logic dataValid, // Data address valid pulse.
	output logic [15:0] immOperand, // Immediate operand.
	output logic immValid, // Immediate operand valid pulse.
	output logic [11:0] extAddr, // External bus address during I/O.
	output logic ioRead, // I/O read pulse.
	output logic ioWrite, // I/O write pulse.
	output logic [31:0] inShifted, // Input shifter result.
	output logic [15:0] outShifted, // Output shifter high word.
	output logic intAck, // Interrupt taken pulse.
	output logic [4:0] intAckId // Taken source, 15 is nonmaskable.
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	agc_pkg::agc_state_t state_reg, state_next;
	agc_pkg::agc_kind_t kind_reg, kind_next;
	logic brUncond_reg, brUncond_next;
	logic captured_reg, captured_next;
	logic modeMc_reg, modeMc_next;
	logic pinPrev_reg, pinPrev_next;
	logic nmiPend_reg, nmiPend_next;
	logic intOff_reg, intOff_next;
	logic [14:0] intMask_reg, intMask_next;
	logic [11:0] pc_reg, pc_next;
	logic [11:0] stack_reg [agc_pkg::STACK_DEPTH];
	logic [11:0] stack_next [agc_pkg::STACK_DEPTH];
	logic [2:0] depth_reg, depth_next;
	logic auxRegPointer_reg, auxRegPointer_next;
	logic page_reg, page_next;
	logic [15:0] auxReg_reg [2];
	logic [15:0] auxReg_next [2];
	logic [15:0] rd_reg, rd_next;
	logic [7:0] dAddr_reg, dAddr_next;
	logic dValid_reg, dValid_next;
	logic [15:0] imm_reg, imm_next;
	logic immV_reg, immV_next;
	logic [11:0] ext_reg, ext_next;
	logic ioRd_reg, ioRd_next;
	logic ioWr_reg, ioWr_next;
	logic [31:0] inSh_reg, inSh_next;
	logic [15:0] outSh_reg, outSh_next;
	logic ack_reg, ack_next;
	logic [4:0] ackId_reg, ackId_next;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	logic [14:0] pending;
	logic isBranch, isRet, isIo, isLarImm, isLacImm, isMulImm;
	logic isPtrImm, isPageImm, isImm, dataOp, selAux;
	logic [4:0] shAmt;
	logic [31:0] accSh;
	logic [15:0] auxMod;
	logic nmiEdge;

	// Opcode classes are pure wiring of the current word.
	assign isBranch = instrWord[15:12] == agc_pkg::OP_BRANCH_HI;
	assign isRet = instrWord == agc_pkg::OP_RET;
	assign isIo = instrWord[15:11] == agc_pkg::OP_IN || instrWord[15:11] == agc_pkg::OP_OUT;
	assign isLarImm = instrWord[15:9] == agc_pkg::OP_LOAD_AUX_IMM;
	assign isLacImm = instrWord[15:8] == agc_pkg::OP_LOAD_ACC_IMM;
	assign isMulImm = instrWord[15:13] == agc_pkg::OP_MUL_IMM;
	assign isPtrImm = instrWord[15:1] == agc_pkg::OP_LOAD_PTR_IMM;
	assign isPageImm = instrWord[15:1] == agc_pkg::OP_LOAD_PAGE_IMM;
	assign isImm = isLarImm || isLacImm || isMulImm; // [RULE13]
	// Operand-free words never reach the addressing logic. [RULE12]
	assign dataOp = !isImm && !isBranch && !isRet && !isPtrImm && !isPageImm &&
		instrWord != agc_pkg::OP_EINT && instrWord != agc_pkg::OP_DINT;
	assign selAux = isLarImm ? instrWord[8] : auxRegPointer_reg; // [RULE14]
	assign pending = irqReq & intMask_reg;
	// Falling edge of the shared pin, only once the strap has been caught.
	assign nmiEdge = captured_reg && pinPrev_reg && !modeSelectNonmaskPin;
	// A shift of sixteen is reached only through the separate select. [RULE17] [RULE15]
	assign shAmt = shiftSixteen ? 5'h10 : {1'b0, instrWord[11:8]};
	// Store shift codes other than 1 and 4 shift by zero. [RULE18] [RULE15]
	assign accSh = instrWord[10:8] == 3'h1 ? {accIn[30:0], 1'b0} :
		instrWord[10:8] == 3'h4 ? {accIn[27:0], 4'h0} : accIn;
	// Auto-modify: bit 5 increments, bit 4 decrements. [RULE11]
	assign auxMod = instrWord[5] ? auxReg_reg[auxRegPointer_reg] + 16'h0001 :
		instrWord[4] ? auxReg_reg[auxRegPointer_reg] - 16'h0001 : auxReg_reg[auxRegPointer_reg];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// The strap is caught by the first clocked edge after release, so no
	// flip-flop ever loads a port value under the asynchronous reset.
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		brUncond_next = brUncond_reg;
		captured_next = 1'b1;
		modeMc_next = captured_reg ? modeMc_reg : modeSelectNonmaskPin; // [RULE1]
		pinPrev_next = modeSelectNonmaskPin;
		nmiPend_next = nmiPend_reg;
		intOff_next = intOff_reg;
		intMask_next = intMask_reg;
		pc_next = pc_reg;
		stack_next = stack_reg;
		depth_next = depth_reg;
		auxRegPointer_next = auxRegPointer_reg;
		page_next = page_reg;
		auxReg_next = auxReg_reg;
		rd_next = 16'h0000;
		dAddr_next = dAddr_reg;
		dValid_next = 1'b0;
		imm_next = imm_reg;
		immV_next = 1'b0;
		ext_next = ext_reg;
		ioRd_next = 1'b0;
		ioWr_next = 1'b0;
		inSh_next = 32'(signed'(loadData)) << shAmt; // [RULE17]
		outSh_next = accSh[31:16]; // [RULE18]
		ack_next = 1'b0;
		ackId_next = ackId_reg;
		// Register port; the reads show the block's own state.
		if (regWr && regAddr == agc_pkg::REG_INT_MASK) begin
			intMask_next = regWrData[14:0];
		end
		if (regRd) begin
			unique case (regAddr)
				agc_pkg::REG_INT_MASK: rd_next = {1'b0, intMask_reg};
				agc_pkg::REG_STATUS: begin
					rd_next[agc_pkg::ST_MODE_BIT] = modeMc_reg;
					rd_next[agc_pkg::ST_INTOFF_BIT] = intOff_reg;
					rd_next[agc_pkg::ST_ARP_BIT] = auxRegPointer_reg;
					rd_next[agc_pkg::ST_DP_BIT] = page_reg;
					rd_next[agc_pkg::ST_DEPTH_LSB +: 3] = depth_reg;
				end
				agc_pkg::REG_AUX_ZERO: rd_next = auxReg_reg[0];
				agc_pkg::REG_AUX_ONE: rd_next = auxReg_reg[1];
			endcase
		end
		// A falling edge after the strap is caught raises the request. [RULE5]
		if (nmiEdge) begin
			nmiPend_next = 1'b1;
		end
		unique case (state_reg)
			agc_pkg::ST_EXEC: begin
				// Nonmaskable request ignores both mask and disable. [RULE5]
				if (nmiPend_reg || (!intOff_reg && |pending)) begin
					// Push shifts down; a fifth level drops the deepest. [RULE4] [RULE20]
					for (int i = agc_pkg::STACK_DEPTH - 1; i > 0; i--) begin
						stack_next[i] = stack_reg[i - 1];
					end
					stack_next[0] = pc_reg;
					depth_next = depth_reg == 3'h4 ? depth_reg : depth_reg + 3'h1;
					intOff_next = 1'b1;
					ack_next = 1'b1;
					if (nmiPend_reg) begin
						nmiPend_next = nmiEdge; // A fresh edge in the take cycle stays pending.
						pc_next = agc_pkg::NMI_VECTOR;
						ackId_next = 5'h0f;
					end else begin
						for (int i = agc_pkg::IRQ_MASKABLE - 1; i >= 0; i--) begin
							if (pending[i]) begin
								ackId_next = 5'(i);
								pc_next = agc_pkg::VECTOR_BASE + 12'(i * 2);
							end
						end
					end
				end else if (instrValid) begin
					pc_next = pc_reg + 12'h001; // [RULE16]
					if (isBranch) begin
						state_next = agc_pkg::ST_SECOND;
						// The second word carries the target, so the condition code is kept here.
						brUncond_next = instrWord[11:8] == agc_pkg::BR_UNCOND;
						kind_next = instrWord[11:8] == agc_pkg::BR_CALL ? agc_pkg::KIND_CALL :
							instrWord[11:8] == agc_pkg::BR_EXT_FLAG ? agc_pkg::KIND_NOP :
							agc_pkg::KIND_BRANCH; // [RULE8]
					end else if (isRet) begin
						pc_next = stack_reg[0];
						for (int i = 0; i < agc_pkg::STACK_DEPTH - 1; i++) begin
							stack_next[i] = stack_reg[i + 1];
						end
						depth_next = depth_reg == 3'h0 ? depth_reg : depth_reg - 3'h1;
					end else if (instrWord == agc_pkg::OP_EINT) begin
						intOff_next = 1'b0;
					end else if (instrWord == agc_pkg::OP_DINT) begin
						intOff_next = 1'b1;
					end else if (isPtrImm) begin
						auxRegPointer_next = instrWord[0];
					end else if (isPageImm) begin
						page_next = instrWord[0];
					end else if (isImm) begin
						immV_next = 1'b1;
						if (isMulImm) begin
							imm_next = 16'(signed'(instrWord[12:0]));
						end else begin
							imm_next = {8'h00, instrWord[7:0]};
						end
						if (isLarImm) begin
							auxReg_next[selAux] = {8'h00, instrWord[7:0]}; // [RULE14]
						end
					end
					if (dataOp) begin
						dValid_next = 1'b1;
						if (!instrWord[7]) begin // [RULE19]
							dAddr_next = {page_reg, instrWord[6:0]}; // [RULE9]
						end else begin
							dAddr_next = auxReg_reg[auxRegPointer_reg][7:0]; // [RULE10]
							auxReg_next[auxRegPointer_reg] = auxMod; // [RULE11]
							if (!instrWord[3]) begin
								auxRegPointer_next = instrWord[0];
							end
						end
					end
					if (isIo) begin
						state_next = agc_pkg::ST_SECOND;
						kind_next = agc_pkg::KIND_IO;
						ext_next = {agc_pkg::IO_UPPER, instrWord[10:8]}; // [RULE6] [RULE7]
						ioRd_next = instrWord[15:11] == agc_pkg::OP_IN;
						ioWr_next = instrWord[15:11] == agc_pkg::OP_OUT;
					end
				end
			end
			agc_pkg::ST_SECOND: begin
				// Branches wait for their address word; I/O simply takes a second cycle.
				if (kind_reg == agc_pkg::KIND_IO) begin
					state_next = agc_pkg::ST_EXEC;
					ext_next = {agc_pkg::IO_UPPER, 3'h0};
				end else if (instrValid) begin
					state_next = agc_pkg::ST_EXEC;
					pc_next = pc_reg + 12'h001;
					unique case (kind_reg)
						agc_pkg::KIND_CALL: begin
							for (int i = agc_pkg::STACK_DEPTH - 1; i > 0; i--) begin
								stack_next[i] = stack_reg[i - 1];
							end
							stack_next[0] = pc_reg + 12'h001; // [RULE4] [RULE20]
							depth_next = depth_reg == 3'h4 ? depth_reg : depth_reg + 3'h1;
							pc_next = instrWord[11:0];
						end
						agc_pkg::KIND_BRANCH: begin
							if (brUncond_reg || branchCond) begin
								pc_next = instrWord[11:0];
							end
						end
						agc_pkg::KIND_NOP: pc_next = pc_reg + 12'h001; // [RULE8]
						agc_pkg::KIND_IO: pc_next = pc_reg;
					endcase
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Interrupts start disabled so software sets the mask before enabling.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= agc_pkg::ST_EXEC;
			kind_reg <= agc_pkg::KIND_BRANCH;
			brUncond_reg <= 1'b0;
			captured_reg <= 1'b0;
			modeMc_reg <= 1'b0;
			pinPrev_reg <= 1'b1;
			nmiPend_reg <= 1'b0;
			intOff_reg <= 1'b1;
			intMask_reg <= agc_pkg::INT_MASK_RESET;
			pc_reg <= agc_pkg::RESET_PC;
			stack_reg <= '{default: 12'h000};
			depth_reg <= 3'h0;
			auxRegPointer_reg <= 1'b0;
			page_reg <= 1'b0;
			auxReg_reg <= '{default: 16'h0000};
			rd_reg <= 16'h0000;
			dAddr_reg <= 8'h00;
			dValid_reg <= 1'b0;
			imm_reg <= 16'h0000;
			immV_reg <= 1'b0;
			ext_reg <= {agc_pkg::IO_UPPER, 3'h0};
			ioRd_reg <= 1'b0;
			ioWr_reg <= 1'b0;
			inSh_reg <= 32'h00000000;
			outSh_reg <= 16'h0000;
			ack_reg <= 1'b0;
			ackId_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			brUncond_reg <= brUncond_next;
			captured_reg <= captured_next;
			modeMc_reg <= modeMc_next;
			pinPrev_reg <= pinPrev_next;
			nmiPend_reg <= nmiPend_next;
			intOff_reg <= intOff_next;
			intMask_reg <= intMask_next;
			pc_reg <= pc_next;
			stack_reg <= stack_next;
			depth_reg <= depth_next;
			auxRegPointer_reg <= auxRegPointer_next;
			page_reg <= page_next;
			auxReg_reg <= auxReg_next;
			rd_reg <= rd_next;
			dAddr_reg <= dAddr_next;
			dValid_reg <= dValid_next;
			imm_reg <= imm_next;
			immV_reg <= immV_next;
			ext_reg <= ext_next;
			ioRd_reg <= ioRd_next;
			ioWr_reg <= ioWr_next;
			inSh_reg <= inSh_next;
			outSh_reg <= outSh_next;
			ack_reg <= ack_next;
			ackId_reg <= ackId_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// The whole 4K space is either on chip or external, never split.
	assign progOnChip = modeMc_reg; // [RULE2]
	assign progExternal = !modeMc_reg; // [RULE3]
	assign progAddr = pc_reg;
	assign busy = state_reg == agc_pkg::ST_SECOND;
	assign regRdData = rd_reg;
	assign dataAddr = dAddr_reg;
	assign dataValid = dValid_reg;
	assign immOperand = imm_reg;
	assign immValid = immV_reg;
	assign extAddr = ext_reg;
	assign ioRead = ioRd_reg;
	assign ioWrite = ioWr_reg;
	assign inShifted = inSh_reg;
	assign outShifted = outSh_reg;
	assign intAck = ack_reg;
	assign intAckId = ackId_reg;
endmodule

// ===== hdl/agc_pkg.sv
// Constants shared by the address generation and mode control block.
package agc_pkg;
	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int PROG_AW = 12;
	localparam int DATA_AW = 8;
	localparam int STACK_DEPTH = 4;
	localparam int IRQ_MASKABLE = 15;
	// ----------------------------------------
	// Register port map (word index)
	// ----------------------------------------
	localparam logic [1:0] REG_INT_MASK = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_AUX_ZERO = 2'h2;
	localparam logic [1:0] REG_AUX_ONE = 2'h3;
	localparam logic [14:0] INT_MASK_RESET = 15'h0000;
	// Status fields: mode, intOff, ptr, page, depth.
	localparam int ST_MODE_BIT = 7;
	localparam int ST_INTOFF_BIT = 6;
	localparam int ST_ARP_BIT = 5;
	localparam int ST_DP_BIT = 4;
	localparam int ST_DEPTH_LSB = 0;
	// ----------------------------------------
	// Addresses
	// ----------------------------------------
	localparam logic [11:0] RESET_PC = 12'h000;
	localparam logic [11:0] VECTOR_BASE = 12'h002;
	localparam logic [11:0] NMI_VECTOR = 12'h020;
	localparam logic [8:0] IO_UPPER = 9'h1ff;
	// ----------------------------------------
	// Opcode patterns
	// ----------------------------------------
	localparam logic [3:0] OP_BRANCH_HI = 4'hf;
	localparam logic [3:0] BR_CALL = 4'h8;
	localparam logic [3:0] BR_UNCOND = 4'h9;
	localparam logic [3:0] BR_EXT_FLAG = 4'h6;
	localparam logic [15:0] OP_RET = 16'h7f8d;
	localparam logic [15:0] OP_EINT = 16'h7f82;
	localparam logic [15:0] OP_DINT = 16'h7f81;
	localparam logic [4:0] OP_IN = 5'h08;
	localparam logic [4:0] OP_OUT = 5'h09;
	localparam logic [6:0] OP_LOAD_AUX_IMM = 7'h38;
	localparam logic [7:0] OP_LOAD_ACC_IMM = 8'h7e;
	localparam logic [2:0] OP_MUL_IMM = 3'h4;
	localparam logic [14:0] OP_LOAD_PTR_IMM = 15'h3440;
	localparam logic [14:0] OP_LOAD_PAGE_IMM = 15'h3700;
	// Two cycle operation kinds.
	typedef enum logic [1:0] {
		KIND_BRANCH = 2'b00,
		KIND_CALL = 2'b01,
		KIND_IO = 2'b10,
		KIND_NOP = 2'b11
	} agc_kind_t;
	typedef enum logic {
		ST_EXEC = 1'b0,
		ST_SECOND = 1'b1
	} agc_state_t;
endpackage

// ===== testbench/agc_core_sva.sv
// Port-level checker for the address generation block.
`timescale 1ns/1ps
module agc_core_sva (
	input wire logic sys_clk, // Core clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic instrValid, // Word present.
	input wire logic [15:0] instrWord, // Instruction word.
	input wire logic [15:0] loadData, // Shifter input.
	input wire logic shiftSixteen, // Shift by sixteen.
	input wire logic [31:0] accIn, // Accumulator.
	input wire logic busy, // Second cycle.
	input wire logic [11:0] progAddr, // Program counter.
	input wire logic progOnChip, // On-chip fetch.
	input wire logic progExternal, // External fetch.
	input wire logic [7:0] dataAddr, // Data address.
	input wire logic dataValid, // Data pulse.
	input wire logic [15:0] immOperand, // Immediate.
	input wire logic immValid, // Immediate pulse.
	input wire logic [11:0] extAddr, // External address.
	input wire logic ioRead, // Read pulse.
	input wire logic ioWrite, // Write pulse.
	input wire logic [31:0] inShifted, // Input shifter.
	input wire logic [15:0] outShifted, // Output shifter.
	input wire logic intAck, // Interrupt taken.
	input wire logic [4:0] intAckId // Taken source.
);
	logic [15:0] prevWord;
	logic [15:0] prevLoad;
	logic [31:0] prevAcc;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Inputs of the previous edge, since the outputs answer one cycle late.
	always_ff @(posedge sys_clk) begin
		prevWord <= instrWord;
		prevLoad <= loadData;
		prevAcc <= accIn;
	end
	io_upper_a: assert property ((ioRead || ioWrite) |-> extAddr[11:3] == agc_pkg::IO_UPPER)
		else $error("upper address lines not high");
	io_port_a: assert property ((ioRead || ioWrite) |-> extAddr[2:0] == prevWord[10:8])
		else $error("port field not on low lines");
	io_busy_a: assert property ((ioRead || ioWrite) |-> busy ##1 !busy)
		else $error("io not two cycles");
	mode_hold_a: assert property ($past(rst_n, 2) |-> $stable(progOnChip) && progOnChip != progExternal)
		else $error("mode changed outside reset");
	imm_excl_a: assert property (immValid |-> !dataValid && !ioRead && !ioWrite)
		else $error("immediate touched data memory");
	direct_addr_a: assert property (dataValid && !prevWord[7] |-> dataAddr[6:0] == prevWord[6:0])
		else $error("direct offset wrong");
	acc_imm_a: assert property (immValid && prevWord[15:8] == agc_pkg::OP_LOAD_ACC_IMM |->
		immOperand == {8'h00, prevWord[7:0]}) else $error("acc immediate wrong");
	mul_imm_a: assert property (immValid && prevWord[15:13] == agc_pkg::OP_MUL_IMM |->
		immOperand == {{3{prevWord[12]}}, prevWord[12:0]}) else $error("multiply immediate wrong");
	in_shift_a: assert property (rst_n && !shiftSixteen && instrWord[11:8] == 4'h0 |=>
		inShifted == {{16{prevLoad[15]}}, prevLoad}) else $error("input shift zero wrong");
	out_shift_a: assert property (instrWord[10:8] == 3'h1 |=> outShifted == prevAcc[30:15])
		else $error("output shift one wrong");
	int_vector_a: assert property (intAck && !$past(instrValid) && !$past(instrValid, 2) |-> progAddr ==
		(intAckId == 5'd15 ? agc_pkg::NMI_VECTOR : agc_pkg::VECTOR_BASE + {6'h00, intAckId, 1'b0}))
		else $error("interrupt vector wrong");
endmodule
bind agc_core agc_core_sva agc_core_sva_inst (.sys_clk, .rst_n, .instrValid, .instrWord, .loadData, .shiftSixteen,
	.accIn, .busy, .progAddr, .progOnChip, .progExternal, .dataAddr, .dataValid, .immOperand, .immValid, .extAddr,
	.ioRead, .ioWrite, .inShifted, .outShifted, .intAck, .intAckId);

// ===== testbench/agc_core_tb.sv
// Self-checking testbench for the address generation block.
`timescale 1ns/1ps
module agc_core_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic modeSelectNonmaskPin = 1'b1;
	logic instrValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic branchCond = 1'b0;
	logic [14:0] irqReq = 15'h0000;
	logic [15:0] loadData = 16'h0000;
	logic shiftSixteen = 1'b0;
	logic [31:0] accIn = 32'h00000000;
	logic [1:0] regAddr = 2'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdData, immOperand, outShifted, rd;
	logic busy, progExternal, progOnChip, dataValid, immValid, ioRead, ioWrite, intAck;
	logic [11:0] progAddr, extAddr;
	logic [7:0] dataAddr, accessCount;
	logic [31:0] inShifted;
	logic [4:0] intAckId;
	logic [2:0] lastPort;
	int n_mismatch = 0;
	int num_checks = 0;
	// ----------------------------------------
	// Clock, design and peripherals
	// ----------------------------------------
	always #50 sys_clk = ~sys_clk;
	agc_core agc_core_inst (.sys_clk, .rst_n, .modeSelectNonmaskPin, .instrValid, .instrWord, .branchCond, .irqReq,
		.loadData, .shiftSixteen, .accIn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .busy, .progAddr,
		.progExternal, .progOnChip, .dataAddr, .dataValid, .immOperand, .immValid, .extAddr, .ioRead, .ioWrite,
		.inShifted, .outShifted, .intAck, .intAckId);
	agc_io_model agc_io_model_inst (.sys_clk, .rst_n, .extAddr, .ioRead, .ioWrite, .lastPort, .accessCount);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// One instruction word; returns inside the cycle that carries its answer.
	task automatic exec(input logic [15:0] w);
		@(posedge sys_clk);
		instrValid <= 1'b1;
		instrWord <= w;
		@(posedge sys_clk);
		instrValid <= 1'b0;
		#1;
	endtask
	task automatic exec2(input logic [15:0] w1, input logic [15:0] w2);
		@(posedge sys_clk);
		instrValid <= 1'b1;
		instrWord <= w1;
		@(posedge sys_clk);
		instrWord <= w2;
		@(posedge sys_clk);
		instrValid <= 1'b0;
		#1;
	endtask
	task automatic regWrite(input logic [1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic regRead(input logic [1:0] a);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1;
		rd = regRdData;
	endtask
	task automatic doReset(input logic pin);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		modeSelectNonmaskPin <= pin;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk(progOnChip, pin, "on-chip fetch");
		chk(progExternal, !pin, "external fetch");
	endtask
	// The bound keeps a lost interrupt from hanging the run; one edge always passes
	// first, so the pulse of an earlier interrupt is not taken for this one.
	task automatic waitAck(input logic [4:0] id, input logic [11:0] vec);
		for (int i = 0; i == 0 || (i < 20 && intAck !== 1'b1); i++) begin
			@(posedge sys_clk);
			#1;
		end
		if (intAck !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH %0t interrupt not taken", $time);
			wrap_up();
		end else begin
			chk(intAckId, id, "taken source");
			chk(progAddr, vec, "vector");
		end
	endtask
	task automatic shiftCase(input logic [15:0] w, input logic s16, input logic [31:0] ei, input logic [15:0] eo);
		@(posedge sys_clk);
		instrWord <= w;
		shiftSixteen <= s16;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(inShifted, ei, "input shifter");
		chk(outShifted, eo, "output shifter");
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testAddressing();
		exec(16'h6e01);
		exec(16'h0005);
		chk({dataValid, dataAddr}, 9'h185, "direct page one");
		exec(16'h6e00);
		exec(16'h007f);
		chk(dataAddr, 8'h7f, "direct page zero");
		exec(16'h7055);
		exec(16'h71aa);
		exec(16'h00a1);
		chk(dataAddr, 8'h55, "indirect first");
		exec(16'h0098);
		chk(dataAddr, 8'haa, "indirect second");
		regWrite(agc_pkg::REG_AUX_ZERO, 16'h0000);
		regRead(agc_pkg::REG_AUX_ZERO);
		chk(rd, 16'h0056, "incremented, write ignored");
		regRead(agc_pkg::REG_AUX_ONE);
		chk(rd, 16'h00a9, "decremented");
		exec(16'h7e5a);
		chk({immValid, dataValid, immOperand}, 18'h2005a, "acc immediate");
		exec(16'h9000);
		chk(immOperand, 16'hf000, "multiply immediate");
	endtask
	// Each port in turn, so a swapped or stuck port line shows.
	task automatic testIo();
		for (int p = 0; p < 8; p++) begin
			exec({agc_pkg::OP_IN, p[2:0], 8'h00});
			chk({busy, ioRead, extAddr}, {2'b11, 9'h1ff, p[2:0]}, "port read");
			@(posedge sys_clk);
			#1;
			chk({lastPort, extAddr}, {p[2:0], 12'hff8}, "port seen");
		end
		exec({agc_pkg::OP_OUT, 3'h5, 8'h00});
		chk({ioWrite, extAddr}, 13'h1ffd, "port write");
		@(posedge sys_clk);
		#1;
		chk({lastPort, accessCount}, {3'h5, 8'h09}, "ports decoded");
	endtask
	task automatic testFlow();
		logic [11:0] t;
		exec2(16'hf900, 16'h0100);
		chk(progAddr, 12'h100, "branch");
		for (int i = 0; i < 5; i++) begin
			t = 12'h200 + 12'(i) * 12'h100;
			exec2(16'hf800, {4'h0, t});
			chk(progAddr, t, "call target");
		end
		regRead(agc_pkg::REG_STATUS);
		chk(rd[2:0], 3'h4, "full stack");
		for (int i = 0; i < 4; i++) begin
			exec(agc_pkg::OP_RET);
			chk(progAddr, 12'h502 - 12'(i) * 12'h100, "return");
		end
		@(posedge sys_clk);
		branchCond <= 1'b1;
		exec2({agc_pkg::OP_BRANCH_HI, agc_pkg::BR_EXT_FLAG, 8'h00}, 16'h0777);
		chk(progAddr, 12'h204, "flag branch falls through");
		exec2(16'hf400, 16'h0777);
		chk(progAddr, 12'h777, "conditional taken");
		branchCond <= 1'b0;
	endtask
	task automatic testIrq();
		regWrite(agc_pkg::REG_INT_MASK, 16'hffff);
		regRead(agc_pkg::REG_INT_MASK);
		chk(rd, 16'h7fff, "fifteen mask bits");
		regWrite(agc_pkg::REG_INT_MASK, 16'h0004);
		exec(agc_pkg::OP_EINT);
		irqReq <= 15'h0008;
		repeat (8) begin
			@(posedge sys_clk);
			#1;
			chk(intAck, 1'b0, "masked source");
		end
		@(posedge sys_clk);
		irqReq <= 15'h000c;
		waitAck(5'd2, 12'h006);
		@(posedge sys_clk);
		irqReq <= 15'h0000;
		modeSelectNonmaskPin <= 1'b0;
		waitAck(5'd15, agc_pkg::NMI_VECTOR);
		@(posedge sys_clk);
		modeSelectNonmaskPin <= 1'b1;
	endtask
	initial begin
		loadData = 16'h8001;
		accIn = 32'h12345678;
		doReset(1'b0);
		doReset(1'b1);
		testAddressing();
		testIo();
		shiftCase(16'h0400, 1'b0, 32'hfff80010, 16'h2345);
		shiftCase(16'h0100, 1'b1, 32'h80010000, 16'h2468);
		shiftCase(16'h0000, 1'b0, 32'hffff8001, 16'h1234);
		testFlow();
		testIrq();
		wrap_up();
	end
endmodule

// ===== testbench/agc_io_model.sv
// Behavioural model of the peripherals on the external I/O bus.
`timescale 1ns/1ps
module agc_io_model (
	input wire logic sys_clk, // Core clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic [11:0] extAddr, // External address.
	input wire logic ioRead, // Read pulse.
	input wire logic ioWrite, // Write pulse.
	output logic [2:0] lastPort, // Port of the last access.
	output logic [7:0] accessCount // Accesses decoded.
);
	// A port decodes only with the upper lines high, so a stray access is not counted.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastPort <= 3'h0;
			accessCount <= 8'h00;
		end else if ((ioRead || ioWrite) && extAddr[11:3] == 9'h1ff) begin
			lastPort <= extAddr[2:0];
			accessCount <= accessCount + 8'h01;
		end
	end
endmodule
